/* File: rtl/adcc_top.sv */
// Converter control: sampling, triggers, result format, APB registers
// Notes on behaviour
// - Converter runs only while enable bit 15 of control register is set.
// - With stop_in_idle set, conversion halts while device is idle.
// - Formats 000, 010, 011 place the 10-bit result in low half.
// - Formats 100 to 111 place the result in the full 32-bit word.
// - Trigger 111 uses an internal counter; codes 100 to 110 reserved.
// - Triggers 001, 010, 011: external pin edge, timer 3 match, charge_time_unit.
// - Trigger 000: software clearing sample_active starts conversion.
// - Software sets sample_active, or device does when auto start set.
// - With nonzero trigger the device clears sample_active itself.
// - Device sets conversion done when a conversion finishes.
// - Software may clear done with 0; clear leaves conversion untouched.
// - Device clears done at the start of each new conversion.
// - 100-pin input select: 0..47 inputs, 48 ref, 49 temp, 50 open.
// - 64-pin input select: 0..27 inputs, 28 ref, 29 temp, 30 open.
// - Input select sits at bits 21-16; bits 15-0 read zero.
// - Control register bits 31-16 always read zero.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module adcc_top #(
	parameter bit PIN100 = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        idle_mode,
	input  wire logic        ext_irq_zero,
	input  wire logic        timer3_match,
	input  wire logic        charge_time_unit_event,
	input  wire logic        conv_ready,
	input  wire logic [9:0]  conv_data,
	output logic             conv_start,
	output logic             sample_hold,
	output logic [5:0]       mux_sel,
	output logic [1:0]       mux_kind,
	output logic             irq
);
	import adcc_pkg::*;

	logic        enable_r, stop_idle_r, auto_start_r, sample_r, done_r;
	logic [2:0]  fmt_r, trig_r;
	logic [5:0]  insel_r;
	logic [7:0]  sample_active_time_r, sample_active_cnt_r;
	logic [3:0]  conv_cnt_r;
	logic [31:0] result_r;
	logic [1:0]  sts_r, mask_r;
	adcc_state_t state_r;
	logic [2:0]  ext_s_r, tmr_s_r, ctm_s_r;
	logic        cr_s1_r, cr_s2_r, cr_d_r;
	logic [31:0] fmt_word, rdata;
	logic        wr, rd_hit, running, trig_evt, conv_go, conv_end;

	// External events pass two flops; edge found on the settled pair
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_s_r <= 3'h0;
			tmr_s_r <= 3'h0;
			ctm_s_r <= 3'h0;
			cr_s1_r <= 1'b0;
			cr_s2_r <= 1'b0;
			cr_d_r  <= 1'b0;
		end else begin
			ext_s_r <= {ext_s_r[1:0], ext_irq_zero};
			tmr_s_r <= {tmr_s_r[1:0], timer3_match};
			ctm_s_r <= {ctm_s_r[1:0], charge_time_unit_event};
			cr_s1_r <= conv_ready;
			cr_s2_r <= cr_s1_r;
			cr_d_r  <= cr_s2_r;
		end
	end

	assign wr = psel && penable && pwrite;
	assign running = enable_r && !(stop_idle_r && idle_mode);

	always_comb begin
		case (trig_r)
			TRG_SOFTWARE: trig_evt = wr && paddr == OFF_CONTROL_ONE
				&& !pwdata[BIT_SAMPLE];
			TRG_EXT_IRQ:  trig_evt = ext_s_r[1] && !ext_s_r[2];
			TRG_TIMER3:   trig_evt = tmr_s_r[1] && !tmr_s_r[2];
			TRG_CHARGE_TIME_UNIT:     trig_evt = ctm_s_r[1] && !ctm_s_r[2];
			TRG_AUTO:     trig_evt = sample_active_cnt_r == sample_active_time_r;
			default:      trig_evt = 1'b0;
		endcase
	end

	assign conv_go  = running && state_r == ADCC_SAMPLE && sample_r
		&& trig_evt;
	assign conv_end = state_r == ADCC_CONVERT && cr_s2_r && !cr_d_r
		&& conv_cnt_r == 4'h0;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= ADCC_IDLE;
			sample_active_cnt_r <= 8'h00;
			conv_cnt_r <= 4'h0;
		end else if (!running) begin
			state_r    <= ADCC_IDLE;
			sample_active_cnt_r <= 8'h00;
			conv_cnt_r <= 4'h0;
		end else begin
			case (state_r)
				ADCC_IDLE: begin
					sample_active_cnt_r <= 8'h00;
					if (sample_r)
						state_r <= ADCC_SAMPLE;
				end
				ADCC_SAMPLE: begin
					if (sample_active_cnt_r != sample_active_time_r)
						sample_active_cnt_r <= sample_active_cnt_r + 8'h01;
					if (conv_go) begin
						state_r    <= ADCC_CONVERT;
						conv_cnt_r <= 4'(CONV_CYCLES - 1);
					end else if (!sample_r)
						state_r <= ADCC_IDLE;
				end
				ADCC_CONVERT: begin
					if (conv_cnt_r != 4'h0)
						conv_cnt_r <= conv_cnt_r - 4'h1;
					if (conv_end)
						state_r <= ADCC_IDLE;
				end
				default: state_r <= ADCC_IDLE;
			endcase
		end
	end

	// Control, input select, sample time and interrupt mask register fields
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_r     <= 1'b0;
			stop_idle_r  <= 1'b0;
			fmt_r        <= 3'h0;
			trig_r       <= 3'h0;
			auto_start_r <= 1'b0;
			insel_r      <= RST_INPUT_SEL;
			sample_active_time_r  <= RST_SAMPLE_TIME;
			mask_r       <= 2'h0;
		end else if (wr) begin
			case (paddr)
				OFF_CONTROL_ONE: begin
					enable_r     <= pwdata[BIT_ENABLE];
					stop_idle_r  <= pwdata[BIT_STOP_IDLE];
					fmt_r        <= pwdata[POS_FORMAT +: 3];
					trig_r       <= pwdata[POS_TRIGGER +: 3];
					auto_start_r <= pwdata[BIT_AUTO_START];
				end
				OFF_INPUT_SELECT:
					insel_r <= pwdata[POS_INPUT_SEL +: 6];
				OFF_SAMPLE_TIME: sample_active_time_r <= pwdata[7:0];
				OFF_IRQ_MASK:    mask_r <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Sample flag: hardware set wins over software clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			sample_r <= 1'b0;
		// Enable and sample may be set by one write
		else if (!enable_r && !(wr && paddr == OFF_CONTROL_ONE
			&& pwdata[BIT_ENABLE]))
			sample_r <= 1'b0;
		else if (conv_go)
			sample_r <= 1'b0;
		else if (auto_start_r && running && state_r == ADCC_IDLE)
			sample_r <= 1'b1;
		else if (wr && paddr == OFF_CONTROL_ONE) begin
			if (pwdata[BIT_SAMPLE])
				sample_r <= 1'b1;
			else if (trig_r == TRG_SOFTWARE)
				sample_r <= 1'b0;
		end
	end

	// Done flag: set on completion wins over a software clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			done_r <= 1'b0;
		else if (conv_end)
			done_r <= 1'b1;
		else if (conv_go)
			done_r <= 1'b0;
		else if (wr && paddr == OFF_CONTROL_ONE && !pwdata[BIT_DONE])
			done_r <= 1'b0;
	end

	adcc_format u_format (
		.raw  (conv_data),
		.fmt  (fmt_r),
		.word (fmt_word)
	);

	// Result latched in the same edge that sets done
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			result_r <= 32'h0;
		else if (conv_end)
			result_r <= fmt_word;
	end

	// Sticky status, write one to clear; new event wins
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			sts_r <= 2'h0;
		else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == IRQ_DONE && conv_end)
					|| (i == IRQ_SAMPLE_END && conv_go))
					sts_r[i] <= 1'b1;
				else if (wr && paddr == OFF_IRQ_STATUS && pwdata[i])
					sts_r[i] <= 1'b0;
			end
		end
	end

	// Analog side drives and irq; mux kind 0 input, 1 ref, 2 temp, 3 open
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_start  <= 1'b0;
			sample_hold <= 1'b0;
			mux_sel     <= 6'h00;
			mux_kind    <= 2'h0;
			irq         <= 1'b0;
		end else begin
			conv_start  <= conv_go;
			sample_hold <= running && sample_r;
			irq         <= |(sts_r & mask_r);
			mux_sel     <= insel_r;
			if (PIN100) begin
				if (insel_r <= 6'h2f)      mux_kind <= 2'h0;
				else if (insel_r == 6'h30) mux_kind <= 2'h1;
				else if (insel_r == 6'h31) mux_kind <= 2'h2;
				else                       mux_kind <= 2'h3;
			end else begin
				if (insel_r <= 6'h1b)      mux_kind <= 2'h0;
				else if (insel_r == 6'h1c) mux_kind <= 2'h1;
				else if (insel_r == 6'h1d) mux_kind <= 2'h2;
				else                       mux_kind <= 2'h3;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		case (paddr)
			OFF_CONTROL_ONE: rdata = {16'h0, enable_r, 1'b0, stop_idle_r,
				2'h0, fmt_r, trig_r, 1'b0, 1'b0, auto_start_r, sample_r,
				done_r};
			OFF_INPUT_SELECT: rdata = {10'h0, insel_r, 16'h0};
			OFF_RESULT:       rdata = result_r;
			OFF_IRQ_STATUS:   rdata = {30'h0, sts_r};
			OFF_IRQ_MASK:     rdata = {30'h0, mask_r};
			OFF_SAMPLE_TIME:  rdata = {24'h0, sample_active_time_r};
			default: begin
				rdata  = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Zero-wait slave; read data registered during setup
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			if (psel && !penable && !pwrite)
				prdata <= rdata;
		end
	end

	a_done_follows_end: assert property (@(posedge ref_clk)
		disable iff (!rst_b) conv_end |=> done_r)
		else $error("done not set after conversion end");
	a_result_with_done: assert property (@(posedge ref_clk)
		disable iff (!rst_b) $rose(done_r) |-> result_r == $past(fmt_word))
		else $error("result not valid with done");
	a_done_cleared_go: assert property (@(posedge ref_clk)
		disable iff (!rst_b) conv_go |=> !done_r)
		else $error("done not cleared at conversion start");
	a_sample_cleared: assert property (@(posedge ref_clk)
		disable iff (!rst_b) conv_go |=> !sample_r ##1 conv_start == 1'b0)
		else $error("sample flag not cleared at trigger");
	a_off_no_start: assert property (@(posedge ref_clk)
		disable iff (!rst_b) !enable_r [*2] |-> !conv_start)
		else $error("conversion started while disabled");
	a_idle_halt: assert property (@(posedge ref_clk)
		disable iff (!rst_b) (stop_idle_r && idle_mode) |=>
		state_r == ADCC_IDLE)
		else $error("converter ran in idle");
	a_reserved_trig: assert property (@(posedge ref_clk)
		disable iff (!rst_b) (trig_r inside {3'h4, 3'h5, 3'h6}) |-> !trig_evt)
		else $error("reserved trigger fired");
	a_ctrl_upper_zero: assert property (@(posedge ref_clk)
		disable iff (!rst_b) (paddr == OFF_CONTROL_ONE) |-> rdata[31:16] == 16'h0)
		else $error("control upper half not zero");
	a_insel_low_zero: assert property (@(posedge ref_clk)
		disable iff (!rst_b) (paddr == OFF_INPUT_SELECT) |-> rdata[15:0] == 16'h0)
		else $error("input select low half not zero");
	a_auto_sets_sample: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		auto_start_r && running && state_r == ADCC_IDLE |=> sample_r)
		else $error("auto start did not set sample flag");
	a_done_not_written: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		!done_r && !conv_end |=> !done_r)
		else $error("done set without a conversion end");
	a_clear_keeps_conv: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		state_r == ADCC_CONVERT && running && !conv_end |=>
		state_r == ADCC_CONVERT)
		else $error("conversion disturbed while running");
	a_sw_trig_start: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		trig_r == TRG_SOFTWARE && running && state_r == ADCC_SAMPLE
		&& sample_r && wr && paddr == OFF_CONTROL_ONE
		&& !pwdata[BIT_SAMPLE] |=> conv_start)
		else $error("software clear did not start conversion");
	a_ext_edge_start: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		trig_r == TRG_EXT_IRQ && running && state_r == ADCC_SAMPLE
		&& sample_r && ext_s_r[1] && !ext_s_r[2] |=> conv_start)
		else $error("pin edge did not start conversion");
	a_start_one_cycle: assert property (@(posedge ref_clk)
		disable iff (!rst_b) conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	a_hold_follows_sample: assert property (@(posedge ref_clk)
		disable iff (!rst_b) running && sample_r |=> sample_hold)
		else $error("sample hold not raised while sampling");
	a_open_kind: assert property (@(posedge ref_clk)
		disable iff (!rst_b)
		insel_r == (PIN100 ? 6'h32 : 6'h1e) |=> mux_kind == 2'h3)
		else $error("open input not decoded");
endmodule

/* File: rtl/adcc_pkg.sv */
// Package of constants and types for the converter control block
package adcc_pkg;
	localparam logic [11:0] OFF_CONTROL_ONE  = 12'h000;
	localparam logic [11:0] OFF_INPUT_SELECT = 12'h010;
	localparam logic [11:0] OFF_RESULT       = 12'h020;
	localparam logic [11:0] OFF_IRQ_STATUS   = 12'h030;
	localparam logic [11:0] OFF_IRQ_MASK     = 12'h034;
	localparam logic [11:0] OFF_SAMPLE_TIME  = 12'h040;

	localparam int BIT_ENABLE      = 15;
	localparam int BIT_STOP_IDLE   = 13;
	localparam int POS_FORMAT      = 8;
	localparam int POS_TRIGGER     = 5;
	localparam int BIT_AUTO_START  = 2;
	localparam int BIT_SAMPLE      = 1;
	localparam int BIT_DONE        = 0;
	localparam int POS_INPUT_SEL   = 16;

	localparam int IRQ_DONE        = 0;
	localparam int IRQ_SAMPLE_END  = 1;

	localparam logic [5:0]  RST_INPUT_SEL   = 6'h00;
	localparam logic [7:0]  RST_SAMPLE_TIME = 8'h10;
	localparam int          CONV_CYCLES     = 12;

	localparam logic [2:0] FMT_INT16    = 3'h0;
	localparam logic [2:0] FMT_FRAC16   = 3'h2;
	localparam logic [2:0] FMT_SFRAC16  = 3'h3;
	localparam logic [2:0] FMT_INT32    = 3'h4;
	localparam logic [2:0] FMT_SINT32   = 3'h5;
	localparam logic [2:0] FMT_FRAC32   = 3'h6;
	localparam logic [2:0] FMT_SFRAC32  = 3'h7;

	localparam logic [2:0] TRG_SOFTWARE = 3'h0;
	localparam logic [2:0] TRG_EXT_IRQ  = 3'h1;
	localparam logic [2:0] TRG_TIMER3   = 3'h2;
	localparam logic [2:0] TRG_CHARGE_TIME_UNIT     = 3'h3;
	localparam logic [2:0] TRG_AUTO     = 3'h7;

	typedef enum logic [1:0] {
		ADCC_IDLE,
		ADCC_SAMPLE,
		ADCC_CONVERT
	} adcc_state_t;
endpackage

/* File: rtl/adcc_format.sv */
// Result word formatter for the converter control block
`timescale 1ns/1ps
module adcc_format (
	input  wire logic [9:0]  raw,
	input  wire logic [2:0]  fmt,
	output logic      [31:0] word
);
	import adcc_pkg::*;

	// Signed forms treat the raw code as offset binary around 512
	logic [9:0] sgn;
	assign sgn = {~raw[9], raw[8:0]};

	always_comb begin
		case (fmt)
			FMT_INT16:   word = {22'h0, raw};
			FMT_FRAC16:  word = {16'h0, raw, 6'h00};
			FMT_SFRAC16: word = {16'h0, sgn, 6'h00};
			FMT_INT32:   word = {22'h0, raw};
			FMT_SINT32:  word = {{22{sgn[9]}}, sgn};
			FMT_FRAC32:  word = {raw, 22'h0};
			FMT_SFRAC32: word = {sgn, 22'h0};
			default:     word = {22'h0, raw};
		endcase
	end
endmodule

/* File: testbench/adcc_conv_model.sv */
// Behavioural converter core answering each start after a delay
`timescale 1ns/1ps
module adcc_conv_model #(
	parameter int DELAY = 20
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       conv_start,
	input  wire logic [9:0] code,
	output logic            conv_ready,
	output logic [9:0]      conv_data
);
	int cnt;
	// Data toggles until due, so an early capture shows up
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			conv_ready <= 1'b0;
			conv_data <= 10'h155;
		end else if (conv_start) begin
			cnt <= DELAY;
			conv_ready <= 1'b0;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			conv_ready <= (cnt == 1);
			conv_data <= (cnt > 3) ? ~conv_data : code;
		end
	end
endmodule

/* File: testbench/adc_sample_convert_control_test.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_sample_convert_control_test;
	import adcc_pkg::*;
	logic        ref_clk, rst_b, psel, penable, pwrite, idle_mode;
	logic        pready, pslverr, conv_start, sample_hold, irq;
	logic        conv_ready, er, seen;
	logic [2:0]  trg;
	logic [5:0]  mux_sel, sel64, ms;
	logic [1:0]  mux_kind, kind64, mk;
	logic [9:0]  conv_data, code;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          err_count = 0;
	int          n_checks = 0;

	adcc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idle_mode(idle_mode),
		.ext_irq_zero(trg[0]), .timer3_match(trg[1]),
		.charge_time_unit_event(trg[2]), .conv_ready(conv_ready),
		.conv_data(conv_data), .conv_start(conv_start),
		.sample_hold(sample_hold), .mux_sel(mux_sel),
		.mux_kind(mux_kind), .irq(irq));
	adcc_conv_model core (.ref_clk(ref_clk), .rst_b(rst_b),
		.conv_start(conv_start), .code(code),
		.conv_ready(conv_ready), .conv_data(conv_data));
	// Second copy only to see the 64-pin input decode
	adcc_top #(.PIN100(1'b0)) dut64 (.ref_clk(ref_clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.idle_mode(idle_mode), .ext_irq_zero(trg[0]),
		.timer3_match(trg[1]), .charge_time_unit_event(trg[2]),
		.conv_ready(conv_ready), .conv_data(conv_data),
		.conv_start(), .sample_hold(), .mux_sel(sel64),
		.mux_kind(kind64), .irq());

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task give_verdict;
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	function automatic logic [31:0] ctl(logic e, logic i, logic [2:0] f,
			logic [2:0] t, logic a, logic s);
		return {16'h0, e, 1'b0, i, 2'b0, f, t, 2'b0, a, s, 1'b0};
	endfunction
	function automatic logic [31:0] fmt_exp(logic [2:0] f, logic [9:0] r);
		logic [9:0] s;
		// Signed forms read the raw code as offset binary
		s = {~r[9], r[8:0]};
		case (f)
			3'h2: return {16'h0, r, 6'h0};
			3'h3: return {16'h0, s, 6'h0};
			3'h5: return {{22{s[9]}}, s};
			3'h6: return {r, 22'h0};
			3'h7: return {s, 22'h0};
			default: return {22'h0, r};
		endcase
	endfunction
	task wait_start(input int lim);
		seen = 1'b0;
		for (int n = 0; n < lim && !seen; n++) begin
			@(posedge ref_clk);
			seen = (conv_start === 1'b1);
		end
	endtask
	task pulse(input logic [2:0] m);
		trg <= m;
		wait_start(30);
		trg <= 3'h0;
		@(posedge ref_clk);
	endtask
	task wait_done;
		for (int n = 0; n < 40; n++) begin
			apb(0, OFF_CONTROL_ONE, 0);
			if (rd[BIT_DONE] === 1'b1)
				break;
		end
	endtask
	task conv_sw(input logic [2:0] f, input logic [9:0] c);
		code <= c;
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, f, 0, 0, 1));
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, f, 0, 0, 0));
		apb(0, OFF_CONTROL_ONE, 0);
		chkb(rd[BIT_DONE], 1'b0);
		chkb(rd[BIT_SAMPLE], 1'b0);
		wait_done;
		chkb(rd[BIT_DONE], 1'b1);
		apb(0, OFF_RESULT, 0);
		chk(rd, fmt_exp(f, c));
	endtask
	task t_regs;
		apb(0, OFF_CONTROL_ONE, 0);
		chk(rd, 32'h0);
		apb(0, OFF_INPUT_SELECT, 0);
		chk(rd, 32'h0);
		apb(0, 12'h0fc, 0);
		chk(rd, 32'h0);
		chkb(er, 1'b1);
		apb(1, OFF_CONTROL_ONE, 32'hffff0000);
		apb(0, OFF_CONTROL_ONE, 0);
		chk(rd, 32'h0);
		chkb(er, 1'b0);
	endtask
	task t_format;
		for (int i = 0; i < 8; i++)
			if (i != 1)
				conv_sw(3'(i), (i % 2) ? 10'h2a5 : 10'h15a);
	endtask
	task t_clear;
		conv_sw(FMT_INT16, 10'h3ff);
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 0, 0, 0));
		apb(0, OFF_CONTROL_ONE, 0);
		chkb(rd[BIT_DONE], 1'b0);
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 0, 0, 1));
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 0, 0, 0));
		// Clearing done mid-conversion must not stop it
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 0, 0, 0));
		wait_done;
		chkb(rd[BIT_DONE], 1'b1);
	endtask
	task t_trig;
		logic [2:0] oh;
		for (int i = 1; i < 4; i++) begin
			oh = 3'(1 << (i - 1));
			code <= 10'h100 + 10'(i);
			apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 3'(i), 0, 1));
			pulse(~oh);
			chkb(seen, 1'b0);
			pulse(oh);
			chkb(seen, 1'b1);
			apb(0, OFF_CONTROL_ONE, 0);
			chkb(rd[BIT_SAMPLE], 1'b0);
			wait_done;
			apb(0, OFF_RESULT, 0);
			chk(rd, {22'h0, code});
		end
	endtask
	task t_auto;
		code <= 10'h0aa;
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, 3'h4, 0, 1));
		pulse(3'h7);
		chkb(seen, 1'b0);
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, TRG_AUTO, 1, 0));
		wait_start(200);
		chkb(seen, 1'b1);
		wait_start(200);
		chkb(seen, 1'b1);
		apb(1, OFF_CONTROL_ONE, 0);
	endtask
	task t_gate;
		apb(1, OFF_CONTROL_ONE, ctl(0, 0, 0, TRG_EXT_IRQ, 0, 1));
		pulse(3'h1);
		chkb(seen, 1'b0);
		chkb(sample_hold, 1'b0);
		apb(1, OFF_CONTROL_ONE, ctl(1, 1, 0, TRG_EXT_IRQ, 0, 1));
		idle_mode <= 1'b1;
		pulse(3'h1);
		chkb(seen, 1'b0);
		chkb(sample_hold, 1'b0);
		apb(1, OFF_CONTROL_ONE, ctl(1, 0, 0, TRG_EXT_IRQ, 0, 1));
		@(posedge ref_clk);
		chkb(sample_hold, 1'b1);
		pulse(3'h1);
		chkb(seen, 1'b1);
		wait_done;
		idle_mode <= 1'b0;
	endtask
	task t_mux;
		logic [5:0] s;
		logic [1:0] k;
		// Converter disabled while the input select is swept; decode ignores the trigger
		apb(1, OFF_CONTROL_ONE, ctl(0, 0, 0, TRG_CHARGE_TIME_UNIT, 0, 0));
		for (int i = 0; i < 10; i++) begin
			s = (i % 5 == 0) ? 6'h00 : 6'(((i < 5) ? 46 : 21) + i);
			k = (i % 5 < 2) ? 2'h0 : 2'(i % 5 - 1);
			apb(1, OFF_INPUT_SELECT, {10'h0, s, 16'hffff});
			apb(0, OFF_INPUT_SELECT, 0);
			ms = (i < 5) ? mux_sel : sel64;
			mk = (i < 5) ? mux_kind : kind64;
			chk(rd, {10'h0, s, 16'h0});
			chk({26'h0, ms}, {26'h0, s});
			chk({30'h0, mk}, {30'h0, k});
		end
	endtask
	task chk_irq(input logic e);
		@(negedge ref_clk);
		chkb(irq, e);
		@(posedge ref_clk);
	endtask
	task t_irq;
		apb(1, OFF_IRQ_MASK, 32'h0);
		apb(1, OFF_IRQ_STATUS, 32'h3);
		conv_sw(FMT_INT16, 10'h012);
		apb(0, OFF_IRQ_STATUS, 0);
		chk(rd, 32'h3);
		chk_irq(1'b0);
		apb(1, OFF_IRQ_MASK, 32'h1);
		chk_irq(1'b1);
		apb(1, OFF_IRQ_STATUS, 32'h1);
		chk_irq(1'b0);
		apb(0, OFF_IRQ_STATUS, 0);
		chk(rd, 32'h2);
	endtask
	initial begin
		#300000;
		err_count++;
		give_verdict;
	end
	initial begin
		{rst_b, psel, penable, pwrite, idle_mode, trg} = '0;
		{paddr, pwdata, code} = '0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		t_regs;
		t_format;
		t_clear;
		t_trig;
		t_auto;
		t_gate;
		t_mux;
		t_irq;
		give_verdict;
	end
endmodule
